/* File: design/vtea_pkg.sv */
// Purpose: Shared constants for the VLAN table access block.
// Assumes: 32-bit AXI4-Lite register bus, byte address = 4 x register index.
// Notes: Three switch ports, sixteen VLAN entries.
`default_nettype none
package vtea_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned NUM_ENTRIES = 16;
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned ENTRY_W = 18;
  localparam int unsigned PREC_W = 15;
  localparam int unsigned VID_W = 12;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned CMD_W = 6;
  localparam int unsigned CFG_W = 7;
  // ==========================================================
  // Register indices and byte addresses
  localparam logic [13:0] IDX_WR_DATA = 14'h180c;
  localparam logic [13:0] IDX_RD_DATA = 14'h180e;
  localparam logic [13:0] IDX_CMD = 14'h1810;
  localparam logic [13:0] IDX_CFG = 14'h1812;
  localparam logic [15:0] ADDR_WR_DATA = {IDX_WR_DATA, 2'b00};
  localparam logic [15:0] ADDR_RD_DATA = {IDX_RD_DATA, 2'b00};
  localparam logic [15:0] ADDR_CMD = {IDX_CMD, 2'b00};
  localparam logic [15:0] ADDR_CFG = {IDX_CFG, 2'b00};
  // ==========================================================
  // Field positions
  localparam int unsigned CMD_RNW_BIT = 5;
  localparam int unsigned CMD_SEL_BIT = 4;
  localparam int unsigned CMD_IDX_MSB = 3;
  localparam int unsigned VID_MSB = 11;
  localparam int unsigned UNTAG0_BIT = 12;
  localparam int unsigned MEMBER0_BIT = 13;
  localparam int unsigned PRIO_LSB = 12;
  localparam int unsigned PRIO_MSB = 14;
  localparam int unsigned CFG_HYBRID_LSB = 0;
  localparam int unsigned CFG_ADMIT_LSB = 3;
  localparam int unsigned CFG_VDIS_BIT = 6;
  // ==========================================================
  // Reset values and the null VID
  localparam logic [11:0] PVID_RST = 12'h001;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [17:0] ENTRY_RST = 18'h00000;
  localparam logic [31:0] RD_DATA_RST = 32'h00000000;
  localparam logic [5:0] CMD_RST = 6'h00;
  localparam logic [6:0] CFG_RST = 7'h00;
  localparam logic [11:0] NULL_VID = 12'h000;
  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Per-port membership and tag-removal bits of an entry
  function automatic logic [2:0] vtea_member_bits(input logic [17:0] e);
    vtea_member_bits = {e[MEMBER0_BIT + 4], e[MEMBER0_BIT + 2], e[MEMBER0_BIT]};
  endfunction

  function automatic logic [2:0] vtea_untag_bits(input logic [17:0] e);
    vtea_untag_bits = {e[UNTAG0_BIT + 4], e[UNTAG0_BIT + 2], e[UNTAG0_BIT]};
  endfunction
endpackage
`default_nettype wire

/* File: design/vtea_tbl_if.sv */
// Purpose: Carrier between the access logic and the table store.
// Assumes: One clock domain.
// Notes: Access and lookup are combinational through the store.
`default_nettype none
interface vtea_tbl_if;
  logic acc_go;
  logic acc_rnw;
  logic acc_sel;
  logic [3:0] acc_idx;
  logic [17:0] acc_wdata;
  logic [17:0] acc_rdata;
  logic [11:0] lk_vid;
  logic lk_hit;
  logic [17:0] lk_entry;
  logic [1:0] lk_port;
  logic [14:0] lk_prec;
  modport tbl (input acc_go, acc_rnw, acc_sel, acc_idx, acc_wdata, lk_vid, lk_port,
               output acc_rdata, lk_hit, lk_entry, lk_prec);
  modport ctl (output acc_go, acc_rnw, acc_sel, acc_idx, acc_wdata, lk_vid, lk_port,
               input acc_rdata, lk_hit, lk_entry, lk_prec);
endinterface
`default_nettype wire

/* File: design/vtea_table.sv */
// Purpose: VLAN table and port default record store with VID lookup.
// Assumes: Index beyond port 2 in the port table is ignored.
// Notes: Lowest matching entry wins a lookup.
`default_nettype none
module vtea_table #(
  parameter int unsigned ENTRIES = vtea_pkg::NUM_ENTRIES,
  parameter int unsigned PORTS = vtea_pkg::NUM_PORTS
) (
  input wire logic clock_i, // Switch clock
  input wire logic rst_i,   // Async reset, high
  vtea_tbl_if.tbl bus       // Access and lookup
);
  logic [17:0] vlan_ff [ENTRIES];
  logic [17:0] nxt_vlan [ENTRIES];
  logic [14:0] prec_ff [PORTS];
  logic [14:0] nxt_prec [PORTS];

  // ==========================================================
  // Table writes
  always_comb begin
    nxt_vlan = vlan_ff;
    nxt_prec = prec_ff;
    if (bus.acc_go && !bus.acc_rnw) begin
      if (bus.acc_sel) begin
        if (32'(bus.acc_idx) < PORTS) begin
          nxt_prec[bus.acc_idx[1:0]] = bus.acc_wdata[14:0];
        end
      end else begin
        nxt_vlan[bus.acc_idx] = bus.acc_wdata;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        vlan_ff[i] <= vtea_pkg::ENTRY_RST;
      end
      for (int p = 0; p < PORTS; p++) begin
        prec_ff[p] <= {vtea_pkg::PRIO_RST, vtea_pkg::PVID_RST};
      end
    end else begin
      vlan_ff <= nxt_vlan;
      prec_ff <= nxt_prec;
    end
  end

  // ==========================================================
  // Reads and lookup
  always_comb begin
    bus.acc_rdata = vtea_pkg::ENTRY_RST;
    if (bus.acc_sel) begin
      if (32'(bus.acc_idx) < PORTS) begin
        bus.acc_rdata = {3'h0, prec_ff[bus.acc_idx[1:0]]};
      end
    end else begin
      bus.acc_rdata = vlan_ff[bus.acc_idx];
    end
  end

  always_comb begin
    bus.lk_hit = 1'b0;
    bus.lk_entry = vtea_pkg::ENTRY_RST;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      // Null VID marks a disabled entry and never matches
      if (vlan_ff[i][vtea_pkg::VID_MSB:0] == bus.lk_vid &&
          bus.lk_vid != vtea_pkg::NULL_VID) begin
        bus.lk_hit = 1'b1;
        bus.lk_entry = vlan_ff[i];
      end
    end
    bus.lk_prec = prec_ff[0];
    if (32'(bus.lk_port) < PORTS) begin
      bus.lk_prec = prec_ff[bus.lk_port];
    end
  end
endmodule
`default_nettype wire

/* File: design/vtea_top.sv */
// Purpose: AXI4-Lite access to the VLAN table and per-port default records,
//   plus the frame classifier that consumes them.
// Assumes: One write and one read at a time on the bus.
// Notes: Classification answers one cycle after rx_valid_i.
//
// Register access over AXI4-Lite is this design's own decision.
`default_nettype none
module vtea_top (
  input wire logic clock_i,          // 125 MHz switch clock
  input wire logic rst_i,            // Async reset, high
  // AXI4-Lite slave
  input wire logic [15:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i,  // Write address valid
  output logic s_axi_awready_o,      // Write address ready
  input wire logic [31:0] s_axi_wdata_i, // Write data
  input wire logic [3:0] s_axi_wstrb_i, // Write strobes
  input wire logic s_axi_wvalid_i,   // Write data valid
  output logic s_axi_wready_o,       // Write data ready
  output logic [1:0] s_axi_bresp_o,  // Write response
  output logic s_axi_bvalid_o,       // Write response valid
  input wire logic s_axi_bready_i,   // Write response ready
  input wire logic [15:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i,  // Read address valid
  output logic s_axi_arready_o,      // Read address ready
  output logic [31:0] s_axi_rdata_o, // Read data
  output logic [1:0] s_axi_rresp_o,  // Read response
  output logic s_axi_rvalid_o,       // Read data valid
  input wire logic s_axi_rready_i,   // Read data ready
  // Frame classification
  input wire logic rx_valid_i,       // Received frame header present
  input wire logic [1:0] rx_port_i,  // Ingress port
  input wire logic rx_tagged_i,      // Frame carries a VLAN tag
  input wire logic [11:0] rx_vid_i,  // VID from the tag
  input wire logic rx_prio_chosen_i, // Another priority source chosen
  input wire logic [2:0] rx_prio_i,  // That chosen priority
  output logic cls_valid_o,          // Classification result valid
  output logic [11:0] cls_vid_o,     // Resolved VID
  output logic [2:0] cls_prio_o,     // Resolved priority
  output logic cls_admit_o,          // Frame admitted on ingress
  output logic [2:0] cls_egress_o,   // Egress broadcast domain ports
  output logic [2:0] cls_untag_o     // Egress ports that strip the tag
);
  vtea_tbl_if tbl_bus ();

  vtea_table #(
    .ENTRIES(vtea_pkg::NUM_ENTRIES),
    .PORTS(vtea_pkg::NUM_PORTS)
  ) u_table (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .bus(tbl_bus)
  );

  // ==========================================================
  // Register state
  logic [17:0] wr_data_ff, nxt_wr_data;
  logic [5:0] cmd_ff, nxt_cmd;
  logic [6:0] cfg_ff, nxt_cfg;
  logic [31:0] rd_data_ff, nxt_rd_data;
  // ==========================================================
  // Write channel state
  logic aw_held_ff, nxt_aw_held;
  logic [15:0] awaddr_ff, nxt_awaddr;
  logic w_held_ff, nxt_w_held;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic commit;
  logic [31:0] merged;
  // ==========================================================
  // Read channel state
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] vtea_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8 * b +: 8] = new_v[8 * b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Write path and table access
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_held = w_held_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_wr_data = wr_data_ff;
    nxt_cmd = cmd_ff;
    nxt_cfg = cfg_ff;
    nxt_rd_data = rd_data_ff;
    merged = 32'h00000000;
    tbl_bus.acc_go = 1'b0;
    if (awready_ff && s_axi_awvalid_i) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = s_axi_awaddr_i;
    end
    if (wready_ff && s_axi_wvalid_i) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata_i;
      nxt_wstrb = s_axi_wstrb_i;
    end
    if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    commit = aw_held_ff && w_held_ff && !bvalid_ff;
    if (commit) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = vtea_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        vtea_pkg::ADDR_WR_DATA: begin
          merged = vtea_merge({14'h0000, wr_data_ff}, wdata_ff, wstrb_ff);
          nxt_wr_data = merged[17:0];
        end
        vtea_pkg::ADDR_CMD: begin
          merged = vtea_merge({26'h0000000, cmd_ff}, wdata_ff, wstrb_ff);
          nxt_cmd = merged[5:0];
          // Writing the command's low byte launches the table access
          tbl_bus.acc_go = wstrb_ff[0];
        end
        vtea_pkg::ADDR_CFG: begin
          merged = vtea_merge({25'h0000000, cfg_ff}, wdata_ff, wstrb_ff);
          nxt_cfg = merged[6:0];
        end
        vtea_pkg::ADDR_RD_DATA: begin
          nxt_bresp = vtea_pkg::RESP_SLVERR;
        end
        default: begin
          nxt_bresp = vtea_pkg::RESP_DECERR;
        end
      endcase
    end
    // Access fields come from the command value being written
    tbl_bus.acc_rnw = nxt_cmd[vtea_pkg::CMD_RNW_BIT];
    tbl_bus.acc_sel = nxt_cmd[vtea_pkg::CMD_SEL_BIT];
    tbl_bus.acc_idx = nxt_cmd[vtea_pkg::CMD_IDX_MSB:0];
    tbl_bus.acc_wdata = wr_data_ff;
    if (tbl_bus.acc_go && tbl_bus.acc_rnw) begin
      nxt_rd_data = {14'h0000, tbl_bus.acc_rdata};
    end
    // Ready again only once the held beat is gone
    nxt_awready = !nxt_aw_held;
    nxt_wready = !nxt_w_held;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 16'h0000;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= vtea_pkg::RESP_OKAY;
      wr_data_ff <= vtea_pkg::ENTRY_RST;
      cmd_ff <= vtea_pkg::CMD_RST;
      cfg_ff <= vtea_pkg::CFG_RST;
      rd_data_ff <= vtea_pkg::RD_DATA_RST;
    end else begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff <= nxt_awaddr;
      w_held_ff <= nxt_w_held;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      wr_data_ff <= nxt_wr_data;
      cmd_ff <= nxt_cmd;
      cfg_ff <= nxt_cfg;
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
    if (arready_ff && s_axi_arvalid_i) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = vtea_pkg::RESP_OKAY;
      unique case (s_axi_araddr_i)
        vtea_pkg::ADDR_WR_DATA: nxt_rdata = {14'h0000, wr_data_ff};
        vtea_pkg::ADDR_CMD: nxt_rdata = {26'h0000000, cmd_ff};
        vtea_pkg::ADDR_CFG: nxt_rdata = {25'h0000000, cfg_ff};
        vtea_pkg::ADDR_RD_DATA: nxt_rdata = rd_data_ff;
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = vtea_pkg::RESP_DECERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= vtea_pkg::RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ==========================================================
  // Frame classification
  logic cls_valid_ff, nxt_cls_valid;
  logic [11:0] cls_vid_ff, nxt_cls_vid;
  logic [2:0] cls_prio_ff, nxt_cls_prio;
  logic cls_admit_ff, nxt_cls_admit;
  logic [2:0] cls_egress_ff, nxt_cls_egress;
  logic [2:0] cls_untag_ff, nxt_cls_untag;
  logic vlan_off;
  logic [2:0] hybrid;
  logic [2:0] admit_out;
  logic [2:0] members;

  always_comb begin
    vlan_off = cfg_ff[vtea_pkg::CFG_VDIS_BIT];
    hybrid = cfg_ff[vtea_pkg::CFG_HYBRID_LSB +: 3];
    admit_out = cfg_ff[vtea_pkg::CFG_ADMIT_LSB +: 3];
    tbl_bus.lk_port = rx_port_i;
    nxt_cls_valid = rx_valid_i;
    nxt_cls_vid = rx_vid_i;
    if (vlan_off || !rx_tagged_i || rx_vid_i == vtea_pkg::NULL_VID) begin
      nxt_cls_vid = tbl_bus.lk_prec[vtea_pkg::VID_MSB:0];
    end
    tbl_bus.lk_vid = nxt_cls_vid;
    nxt_cls_prio = tbl_bus.lk_prec[vtea_pkg::PRIO_MSB:vtea_pkg::PRIO_LSB];
    if (rx_prio_chosen_i) begin
      nxt_cls_prio = rx_prio_i;
    end
    members = tbl_bus.lk_hit ? vtea_pkg::vtea_member_bits(tbl_bus.lk_entry) : 3'h0;
    nxt_cls_admit = members[rx_port_i] || admit_out[rx_port_i];
    nxt_cls_egress = members;
    // Hybrid egress ports drop the tag when the entry asks for it
    nxt_cls_untag = members & hybrid & vtea_pkg::vtea_untag_bits(tbl_bus.lk_entry);
    if (vlan_off) begin
      // With VLANs off every frame from ports 0 to 2 floods untouched
      nxt_cls_admit = 1'b1;
      nxt_cls_egress = 3'h7;
      nxt_cls_untag = 3'h0;
    end
    if (rx_port_i == 2'h3) begin
      nxt_cls_admit = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cls_valid_ff <= 1'b0;
      cls_vid_ff <= 12'h000;
      cls_prio_ff <= 3'h0;
      cls_admit_ff <= 1'b0;
      cls_egress_ff <= 3'h0;
      cls_untag_ff <= 3'h0;
    end else begin
      cls_valid_ff <= nxt_cls_valid;
      cls_vid_ff <= nxt_cls_vid;
      cls_prio_ff <= nxt_cls_prio;
      cls_admit_ff <= nxt_cls_admit;
      cls_egress_ff <= nxt_cls_egress;
      cls_untag_ff <= nxt_cls_untag;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign cls_valid_o = cls_valid_ff;
  assign cls_vid_o = cls_vid_ff;
  assign cls_prio_o = cls_prio_ff;
  assign cls_admit_o = cls_admit_ff;
  assign cls_egress_o = cls_egress_ff;
  assign cls_untag_o = cls_untag_ff;
endmodule
`default_nettype wire

/* File: sim/vtea_top_chk.sv */
// Purpose: Port-level checks for the VLAN table access block.
// Assumes: Software never sets a default VID of zero.
// Notes: Bound to vtea_top after the module.
`default_nettype none
module vtea_top_chk (
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [15:0] s_axi_awaddr_i, // AW addr
  input wire logic s_axi_awvalid_i, // AW valid
  input wire logic s_axi_awready_o, // AW ready
  input wire logic [1:0] s_axi_bresp_o, // B resp
  input wire logic s_axi_bvalid_o, // B valid
  input wire logic s_axi_bready_i, // B ready
  input wire logic [15:0] s_axi_araddr_i, // AR addr
  input wire logic s_axi_arvalid_i, // AR valid
  input wire logic s_axi_arready_o, // AR ready
  input wire logic [31:0] s_axi_rdata_o, // R data
  input wire logic [1:0] s_axi_rresp_o, // R resp
  input wire logic s_axi_rvalid_o, // R valid
  input wire logic s_axi_rready_i, // R ready
  input wire logic rx_valid_i, // Frame
  input wire logic rx_tagged_i, // Tagged
  input wire logic [11:0] rx_vid_i, // Tag VID
  input wire logic rx_prio_chosen_i, // Prio given
  input wire logic [2:0] rx_prio_i, // Given prio
  input wire logic [11:0] cls_vid_o, // VID out
  input wire logic [2:0] cls_prio_o, // Prio out
  input wire logic [2:0] cls_egress_o, // Egress
  input wire logic [2:0] cls_untag_o // Untag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] aw_ff;
  logic [15:0] nxt_aw;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ========
  // Last accepted write address
  always_comb nxt_aw = (s_axi_awvalid_i && s_axi_awready_o) ? s_axi_awaddr_i : aw_ff;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) aw_ff <= 16'h0000;
    else aw_ff <= nxt_aw;
  end
  // ========
  // Checks
  prio_pick_a: assert property (rx_valid_i && rx_prio_chosen_i |=>
    cls_prio_o == $past(rx_prio_i)) else $error("chosen priority not used");
  null_vid_a: assert property (rx_valid_i && (!rx_tagged_i || rx_vid_i == 12'h000) |=>
    cls_vid_o != 12'h000) else $error("untagged frame left with null VID");
  untag_sub_a: assert property ((cls_untag_o & ~cls_egress_o) == 3'h0)
    else $error("untag on a non-member port");
  ro_slverr_a: assert property (s_axi_bvalid_o && aw_ff == vtea_pkg::ADDR_RD_DATA |->
    s_axi_bresp_o == vtea_pkg::RESP_SLVERR) else $error("read data register took a write");
  rd_okay_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i == vtea_pkg::ADDR_RD_DATA |=> s_axi_rvalid_o &&
    s_axi_rresp_o == vtea_pkg::RESP_OKAY) else $error("read data answer late or bad");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data not held");
  resp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer not held");
  rsv_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:18] == 14'h0000)
    else $error("reserved read bits set");
  wr_seen_c: cover property (s_axi_bvalid_o && s_axi_bready_i);
  rd_stall_c: cover property (s_axi_rvalid_o && !s_axi_rready_i);
  untag_c: cover property (cls_untag_o != 3'h0);
endmodule
bind vtea_top vtea_top_chk chk (.clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .rx_valid_i, .rx_tagged_i, .rx_vid_i, .rx_prio_chosen_i, .rx_prio_i,
  .cls_vid_o, .cls_prio_o, .cls_egress_o, .cls_untag_o);
`default_nettype wire

/* File: sim/vtea_mgmt_model.sv */
// Purpose: Management software model on the register bus.
// Assumes: One transfer at a time, full-word writes.
// Notes: lag delays bready and rready.
`default_nettype none
module vtea_mgmt_model (
  input wire logic clock_i, // Clock
  output logic [15:0] awaddr_o, // AW addr
  output logic awvalid_o, // AW valid
  input wire logic awready_i, // AW ready
  output logic [31:0] wdata_o, // W data
  output logic [3:0] wstrb_o, // W lanes
  output logic wvalid_o, // W valid
  input wire logic wready_i, // W ready
  input wire logic [1:0] bresp_i, // B resp
  input wire logic bvalid_i, // B valid
  output logic bready_o, // B ready
  output logic [15:0] araddr_o, // AR addr
  output logic arvalid_o, // AR valid
  input wire logic arready_i, // AR ready
  input wire logic [31:0] rdata_i, // R data
  input wire logic [1:0] rresp_i, // R resp
  input wire logic rvalid_i, // R valid
  output logic rready_o // R ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag = 0;
  assign wstrb_o = 4'hf;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end
  // ========
  // Released lines show inverted junk so stale values never pass
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    {ad, wd} = 2'b00;
    {awaddr_o, wdata_o, awvalid_o, wvalid_o} <= {a, d, 2'b11};
    while (!(ad && wd)) begin
      @(posedge clock_i);
      if (!ad && awready_i) begin
        ad = 1'b1;
        {awvalid_o, awaddr_o} <= {1'b0, ~a};
      end
      if (!wd && wready_i) begin
        wd = 1'b1;
        {wvalid_o, wdata_o} <= {1'b0, ~d};
      end
    end
    repeat (lag) @(posedge clock_i);
    bready_o <= 1'b1;
    do @(posedge clock_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    {araddr_o, arvalid_o} <= {a, 1'b1};
    do @(posedge clock_i); while (!arready_i);
    {araddr_o, arvalid_o} <= {~a, 1'b0};
    repeat (lag) @(posedge clock_i);
    rready_o <= 1'b1;
    do @(posedge clock_i); while (!rvalid_i);
    {d, r} = {rdata_i, rresp_i};
    rready_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: sim/vlan_table_entry_access_test.sv */
// Purpose: Self-checking bench for the VLAN table access block.
// Assumes: The management model drives the register bus.
// Notes: Reset and port default reads first, then register rows, then hand-written cases.
`default_nettype none
module vlan_table_entry_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0] cmd;
    logic [31:0] wd;
    logic [31:0] exp;
  } vtea_row_t;
  logic clock_i, rst_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic s_axi_rready_i, rx_valid_i, rx_tagged_i, rx_prio_chosen_i, cls_valid_o, cls_admit_o;
  logic [15:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, data;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rx_port_i, resp;
  logic [11:0] rx_vid_i, cls_vid_o;
  logic [2:0] rx_prio_i, cls_prio_o, cls_egress_o, cls_untag_o;
  int failures = 0;
  int checked = 0;
  // Entry VIDs avoid zero and 3FFh, default VIDs avoid zero and FFFh
  vtea_row_t rows [6] = '{
    '{6'h00, 32'h0000e005, 32'h0000e005},
    '{6'h0f, 32'hffffffff, 32'h0003ffff},
    '{6'h01, 32'h00030abc, 32'h00030abc},
    '{6'h12, 32'h0003d123, 32'h00005123},
    '{6'h13, 32'h00000456, 32'h00000000},
    '{6'h10, 32'h00000007, 32'h00000007}};
  vtea_top dut (.clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .rx_valid_i, .rx_port_i,
    .rx_tagged_i, .rx_vid_i, .rx_prio_chosen_i, .rx_prio_i, .cls_valid_o, .cls_vid_o,
    .cls_prio_o, .cls_admit_o, .cls_egress_o, .cls_untag_o);
  vtea_mgmt_model mgmt (.clock_i, .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));
  // ========
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [5:0] c);
    mgmt.wr(vtea_pkg::ADDR_CMD, {26'h0, c}, resp);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    mgmt.rd(a, data, resp);
    chk(data, e);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic frame(input logic [6:0] c, input logic [1:0] p, input logic t,
      input logic [11:0] v, input logic pc, input logic [2:0] pr, input logic [21:0] e);
    mgmt.wr(vtea_pkg::ADDR_CFG, {25'h0, c}, resp);
    {rx_port_i, rx_tagged_i, rx_vid_i, rx_prio_chosen_i, rx_prio_i, rx_valid_i} <=
      {p, t, v, pc, pr, 1'b1};
    @(posedge clock_i);
    rx_valid_i <= 1'b0;
    #1;
    chk({9'h0, cls_valid_o, cls_vid_o, cls_prio_o, cls_admit_o, cls_egress_o, cls_untag_o},
      {9'h0, 1'b1, e});
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ========
  // Sequence
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial begin
    repeat (6000) @(posedge clock_i);
    failures++;
    wrap_up();
  end
  initial begin
    rst_i = 1'b1;
    {rx_valid_i, rx_port_i, rx_tagged_i, rx_vid_i, rx_prio_chosen_i, rx_prio_i} = '0;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rdchk(vtea_pkg::ADDR_RD_DATA, 32'h0, vtea_pkg::RESP_OKAY);
    for (int p = 0; p < 3; p++) begin
      cmd(6'h30 | 6'(p));
      rdchk(vtea_pkg::ADDR_RD_DATA, 32'h00000001, vtea_pkg::RESP_OKAY);
    end
    foreach (rows[i]) begin
      mgmt.wr(vtea_pkg::ADDR_WR_DATA, rows[i].wd, resp);
      cmd(rows[i].cmd);
      cmd(rows[i].cmd | 6'h20);
      rdchk(vtea_pkg::ADDR_RD_DATA, rows[i].exp, vtea_pkg::RESP_OKAY);
    end
    // Slow answers; read data must stay put
    mgmt.lag = 2;
    cmd(6'h21);
    mgmt.wr(vtea_pkg::ADDR_WR_DATA, 32'h00002222, resp);
    cmd(6'h02);
    mgmt.wr(vtea_pkg::ADDR_RD_DATA, 32'h0, resp);
    chk({30'h0, resp}, {30'h0, vtea_pkg::RESP_SLVERR});
    rdchk(vtea_pkg::ADDR_RD_DATA, 32'h00030abc, vtea_pkg::RESP_OKAY);
    mgmt.wr(16'h0100, 32'h1, resp);
    chk({30'h0, resp}, {30'h0, vtea_pkg::RESP_DECERR});
    rdchk(16'h0100, 32'h0, vtea_pkg::RESP_DECERR);
    mgmt.lag = 0;
    frame(7'h07, 2'd1, 1'b1, 12'h005, 1'b0, 3'h0, {12'h005, 3'h0, 1'b1, 3'h3, 3'h2});
    frame(7'h07, 2'd0, 1'b0, 12'h005, 1'b0, 3'h0, {12'h007, 3'h0, 1'b0, 3'h0, 3'h0});
    frame(7'h07, 2'd2, 1'b1, 12'h000, 1'b0, 3'h0, {12'h123, 3'h5, 1'b0, 3'h0, 3'h0});
    frame(7'h07, 2'd2, 1'b1, 12'habc, 1'b1, 3'h3, {12'habc, 3'h3, 1'b1, 3'h4, 3'h4});
    frame(7'h07, 2'd0, 1'b1, 12'habc, 1'b0, 3'h0, {12'habc, 3'h0, 1'b0, 3'h4, 3'h4});
    frame(7'h07, 2'd1, 1'b1, 12'hfff, 1'b0, 3'h0, {12'hfff, 3'h0, 1'b1, 3'h7, 3'h7});
    frame(7'h08, 2'd0, 1'b1, 12'habc, 1'b0, 3'h0, {12'habc, 3'h0, 1'b1, 3'h4, 3'h0});
    frame(7'h08, 2'd3, 1'b1, 12'habc, 1'b0, 3'h0, {12'habc, 3'h0, 1'b0, 3'h4, 3'h0});
    frame(7'h40, 2'd1, 1'b1, 12'habc, 1'b0, 3'h0, {12'h001, 3'h0, 1'b1, 3'h7, 3'h0});
    wrap_up();
  end
endmodule
`default_nettype wire
